// *** logic/sfc_pkg.sv ***
// Overview of operation
// - config bit 7 low selects four-line protocol
// - config bit 6 low selects two-line protocol
// - both low means four-line; applies after write
// - config bit 4 enables hold/reset pin
// - config bit 3 low enables program acceleration
// - bits 2:0 drive code, 000/100 reserved
// - config read/write accepted in every protocol
// - flag bit 7 low while operation busy
// - flag bits 6/2 show erase/program suspend
// - flag bit 5 set on erase failure
// - flag bit 4 set on program failure
// - flag bit 3 set on bad program voltage
// - flag bit 1 set on protected target
// - busy and suspend bits clear themselves
// - error bits held until clear command 50h
// - program/erase with error pending flags protection
// - flag register read by 70h, endless bytes
// - two-line io read refused in four-line
// - four-line io read refused in two-line
// - id 9E/9F extended only, AFh multi-line only
// - nonvolatile config read B5h, write B1h
// - 6Bh not in two-line, 3Bh not four-line
// - writes, programs, erases need write enable first
// - config read repeats same byte until deselect
package sfc_pkg;
   typedef enum logic [1:0] {
      PR_EXT  = 2'h0,
      PR_DUAL = 2'h1,
      PR_QUAD = 2'h2
   } sfc_proto_t;
   typedef enum logic [1:0] {
      ST_CMD  = 2'h0,
      ST_DIN  = 2'h1,
      ST_DOUT = 2'h3,
      ST_SKIP = 2'h2
   } sfc_state_t;
   localparam logic [7:0] CFG_RST    = 8'hDF;
   localparam int         CFG_B_QUAD = 7;
   localparam int         CFG_B_DUAL = 6;
   localparam int         CFG_B_RSV  = 5;
   localparam int         CFG_B_HOLD = 4;
   localparam int         CFG_B_ACC  = 3;
   localparam logic [2:0] DRV_RSV0   = 3'h0;
   localparam logic [2:0] DRV_RSV1   = 3'h4;
   localparam logic [2:0] ST_RST     = 3'h4;
   localparam logic       FLAG_RSV   = 1'b0;
   localparam logic [4:0] ID_LEN_EXT = 5'h14;
   localparam logic [4:0] ID_LEN_MIO = 5'h03;
   localparam logic [7:0] C_RSTEN  = 8'h66;
   localparam logic [7:0] C_RSTMEM = 8'h99;
   localparam logic [7:0] C_ID1    = 8'h9E;
   localparam logic [7:0] C_ID2    = 8'h9F;
   localparam logic [7:0] C_IDM    = 8'hAF;
   localparam logic [7:0] C_SFDP   = 8'h5A;
   localparam logic [7:0] C_RD     = 8'h03;
   localparam logic [7:0] C_FRD    = 8'h0B;
   localparam logic [7:0] C_DOFR   = 8'h3B;
   localparam logic [7:0] C_DIOFR  = 8'hBB;
   localparam logic [7:0] C_QOFR   = 8'h6B;
   localparam logic [7:0] C_QIOFR  = 8'hEB;
   localparam logic [7:0] C_WREN   = 8'h06;
   localparam logic [7:0] C_WRDI   = 8'h04;
   localparam logic [7:0] C_RDSR   = 8'h05;
   localparam logic [7:0] C_RDFLG  = 8'h70;
   localparam logic [7:0] C_CLRFLG = 8'h50;
   localparam logic [7:0] C_RDNV   = 8'hB5;
   localparam logic [7:0] C_WRNV   = 8'hB1;
   localparam logic [7:0] C_RDEVC  = 8'h65;
   localparam logic [7:0] C_WREVC  = 8'h61;
   localparam logic [7:0] C_PP     = 8'h02;
   localparam logic [7:0] C_DIFP   = 8'hA2;
   localparam logic [7:0] C_DIEFP  = 8'hD2;
   localparam logic [7:0] C_QIFP   = 8'h32;
   localparam logic [7:0] C_QIEFP  = 8'h12;
   localparam logic [7:0] C_SSE    = 8'h20;
   localparam logic [7:0] C_SE     = 8'hD8;
   localparam logic [7:0] C_BE     = 8'hC7;
   localparam logic [7:0] C_RDOTP  = 8'h4B;
   localparam logic [7:0] C_PGOTP  = 8'h42;
endpackage

// *** logic/sfc_sync.sv ***
`timescale 1ns/10ps
module sfc_sync (
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst_n,
   input  wire logic [5:0] i_async,
   output logic [5:0]      o_sync,
   output logic            o_rise,
   output logic            o_fall
);
   // bit 5 link clock, bit 4 select (idle high), bits 3:0 data
   logic [5:0] meta;
   logic       clk_d;

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta   <= 6'h10;
         o_sync <= 6'h10;
         clk_d  <= 1'b0;
      end else begin
         meta   <= i_async;
         o_sync <= meta;
         clk_d  <= o_sync[5];
      end
   end

   // data and clock share the same latency, so edges stay aligned
   assign o_rise = o_sync[5] & ~clk_d;
   assign o_fall = ~o_sync[5] & clk_d;
endmodule

// *** logic/sfc_cmd.sv ***
`timescale 1ns/10ps
module sfc_cmd
   import sfc_pkg::*;
#(
   parameter logic [23:0] ID_BYTES = 24'h5A0C31 // arbitrary value
)(
   input  wire logic        i_clk_sys,
   input  wire logic        i_nrst,
   input  wire logic        i_link_clk,
   input  wire logic        i_sel_n,
   input  wire logic [3:0]  i_dq,
   output logic [3:0]       o_dq,
   output logic [3:0]       o_dq_oe_n,
   input  wire logic        i_op_busy,
   input  wire logic        i_erase_susp,
   input  wire logic        i_prog_susp,
   input  wire logic        i_erase_fail,
   input  wire logic        i_prog_fail,
   input  wire logic        i_vpp_bad,
   input  wire logic        i_prot_hit,
   input  wire logic [7:0]  i_status,
   input  wire logic [15:0] i_nvcfg,
   output logic             o_array_start,
   output logic [7:0]       o_array_code,
   output logic             o_read_start,
   output logic [7:0]       o_read_code,
   output logic             o_nvcfg_wr,
   output logic [15:0]      o_nvcfg_data,
   output logic             o_mem_reset,
   output logic [1:0]       o_protocol,
   output logic             o_hold_en,
   output logic             o_accel_en,
   output logic [2:0]       o_drive_code,
   output logic             o_wel
);
   logic [1:0]  rst_q;
   logic [5:0]  syn;
   logic [3:0]  dq_s, lane_w, lane_m, bc, bc_sum, tc, tc_sum, err;
   logic [7:0]  cfg, next_cfg, flags, rx_sh, next_rx, tx_sh, cur, nv_lo;
   logic [2:0]  st;
   logic [4:0]  bi;
   sfc_proto_t  proto;
   sfc_state_t  state, next_state;
   logic        rst_n, lk_rise, lk_fall, sel_n_s, wel, rst_arm;
   logic        rx_on, byte_done, cmd_done, din_done, tx_on;
   logic        cv, hit, is_out, is_in, is_arr, is_rd;
   logic        c_clr, c_arr, arr_go, arr_err, c_win;
   logic        cfg_wr, nv_wr, err_any;

   function automatic logic cmd_valid(input logic [7:0] c,
                                      input sfc_proto_t p);
      logic r;
      r = 1'b0;
      unique case (c)
         C_RSTEN, C_RSTMEM, C_WREN, C_WRDI, C_RDSR, C_RDFLG, C_CLRFLG,
         C_RDNV, C_WRNV, C_RDEVC, C_WREVC, C_FRD, C_SFDP, C_SSE, C_SE,
         C_BE, C_PP, C_RDOTP, C_PGOTP: r = 1'b1;
         C_ID1, C_ID2, C_RD:           r = (p == PR_EXT);
         C_IDM:                        r = (p != PR_EXT);
         C_DOFR, C_DIOFR, C_DIFP, C_DIEFP:
                                       r = (p != PR_QUAD);
         C_QOFR, C_QIOFR, C_QIFP, C_QIEFP:
                                       r = (p != PR_DUAL);
         default:                      r = 1'b0;
      endcase
      return r;
   endfunction

   // byte i of the answer to command c
   function automatic logic [7:0] out_sel(input logic [7:0] c,
                                          input logic [4:0] i);
      logic [7:0] b;
      b = 8'h00;
      if (c == C_RDFLG)
         b = flags;
      else if (c == C_RDEVC)
         b = cfg;
      else if (c == C_RDSR)
         b = i_status;
      else if (c == C_RDNV)
         b = (i == 5'h00) ? i_nvcfg[7:0] :
             (i == 5'h01) ? i_nvcfg[15:8] : 8'h00;
      else if (i < ID_LEN_MIO)
         b = ID_BYTES[8 * (2 - int'(i)) +: 8];
      return b;
   endfunction

   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   sfc_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (rst_n),
      .i_async   ({i_link_clk, i_sel_n, i_dq}),
      .o_sync    (syn),
      .o_rise    (lk_rise),
      .o_fall    (lk_fall)
   );
   assign sel_n_s = syn[4];
   assign dq_s    = syn[3:0];

   // protocol decode from the live config register
   assign proto = !cfg[CFG_B_QUAD] ? PR_QUAD :
                  !cfg[CFG_B_DUAL] ? PR_DUAL : PR_EXT;
   assign lane_w = (proto == PR_QUAD) ? 4'h4 :
                   (proto == PR_DUAL) ? 4'h2 : 4'h1;
   assign lane_m = (proto == PR_QUAD) ? 4'hF :
                   (proto == PR_DUAL) ? 4'h3 : 4'h2;

   assign rx_on   = lk_rise & ~sel_n_s & (state == ST_CMD ||
                                          state == ST_DIN);
   assign next_rx = (proto == PR_QUAD) ? {rx_sh[3:0], dq_s} :
                    (proto == PR_DUAL) ? {rx_sh[5:0], dq_s[1:0]} :
                                         {rx_sh[6:0], dq_s[0]};
   assign bc_sum    = bc + lane_w;
   assign byte_done = rx_on & bc_sum[3];
   assign cmd_done  = byte_done & (state == ST_CMD);
   assign din_done  = byte_done & (state == ST_DIN);
   assign tx_on     = lk_fall & ~sel_n_s & (state == ST_DOUT);
   assign tc_sum    = tc + lane_w;

   // command classification of the byte just received
   assign cv     = cmd_valid(next_rx, proto);
   assign hit    = cmd_done & cv;
   assign is_out = next_rx == C_RDFLG || next_rx == C_RDEVC ||
                   next_rx == C_RDSR || next_rx == C_RDNV ||
                   next_rx == C_ID1 || next_rx == C_ID2 ||
                   next_rx == C_IDM;
   assign is_in  = next_rx == C_WREVC || next_rx == C_WRNV;
   assign is_arr = next_rx == C_PP || next_rx == C_DIFP ||
                   next_rx == C_DIEFP || next_rx == C_QIFP ||
                   next_rx == C_QIEFP || next_rx == C_SSE ||
                   next_rx == C_SE || next_rx == C_BE ||
                   next_rx == C_PGOTP;
   assign is_rd  = next_rx == C_RD || next_rx == C_FRD ||
                   next_rx == C_DOFR || next_rx == C_DIOFR ||
                   next_rx == C_QOFR || next_rx == C_QIOFR ||
                   next_rx == C_SFDP || next_rx == C_RDOTP;
   assign c_clr   = hit & (next_rx == C_CLRFLG);
   assign err_any = |err;
   assign c_arr   = hit & is_arr;
   assign arr_go  = c_arr & wel & ~err_any;
   assign arr_err = c_arr & err_any;
   assign c_win   = hit & is_in & wel;
   assign cfg_wr  = din_done & (cur == C_WREVC);
   // bi is 1 after the command, 2 once the low byte is in
   assign nv_wr   = din_done & (cur == C_WRNV) & (bi == 5'h02);

   always_comb begin
      next_state = state;
      if (cmd_done)
         next_state = (hit & is_out) ? ST_DOUT :
                      c_win ? ST_DIN : ST_SKIP;
      else if (cfg_wr || nv_wr)
         next_state = ST_SKIP;
   end

   // reserved bit forced low; reserved drive codes keep the old code
   always_comb begin
      next_cfg = cfg;
      if (cfg_wr) begin
         next_cfg = next_rx & ~(8'h01 << CFG_B_RSV);
         if (next_rx[2:0] == DRV_RSV0 || next_rx[2:0] == DRV_RSV1)
            next_cfg[2:0] = cfg[2:0];
      end else if (hit && next_rx == C_RSTMEM && rst_arm)
         next_cfg = CFG_RST;
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_CMD;
         bc    <= 4'h0;
         rx_sh <= 8'h00;
         cur   <= 8'h00;
         nv_lo <= 8'h00;
      end else if (sel_n_s) begin
         state <= ST_CMD;
         bc    <= 4'h0;
      end else begin
         state <= next_state;
         if (rx_on) begin
            rx_sh <= next_rx;
            bc    <= byte_done ? 4'h0 : bc_sum;
         end
         if (cmd_done)
            cur <= next_rx;
         if (din_done)
            nv_lo <= next_rx;
      end
   end

   // output shifter; lanes launch on the link clock falling edge
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh     <= 8'h00;
         tc        <= 4'h0;
         bi        <= 5'h00;
         o_dq      <= 4'h0;
         o_dq_oe_n <= 4'hF;
      end else if (sel_n_s) begin
         tc        <= 4'h0;
         bi        <= 5'h00;
         o_dq_oe_n <= 4'hF;
      end else if (cmd_done) begin
         tx_sh <= out_sel(next_rx, 5'h00);
         tc    <= 4'h0;
         bi    <= 5'h01;
      end else if (din_done) begin
         bi <= bi + 5'h01;
      end else if (tx_on) begin
         o_dq_oe_n <= ~lane_m;
         o_dq      <= (proto == PR_QUAD) ? tx_sh[7:4] :
                      (proto == PR_DUAL) ? {2'h0, tx_sh[7:6]} :
                                           {2'h0, tx_sh[7], 1'b0};
         tc        <= tc_sum[3] ? 4'h0 : tc_sum;
         tx_sh     <= tc_sum[3] ? out_sel(cur, bi) : tx_sh << lane_w;
         if (tc_sum[3] && bi != ID_LEN_EXT)
            bi <= bi + 5'h01;
      end
   end

   // status bits follow the array; error bits are sticky, set wins
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st  <= ST_RST;
         err <= 4'h0;
      end else begin
         st  <= {~i_op_busy, i_erase_susp, i_prog_susp};
         err <= {i_erase_fail, i_prog_fail, i_vpp_bad,
                 i_prot_hit | arr_err} | (err & {4{~c_clr}});
      end
   end
   assign flags = {st[2], st[1], err[3], err[2], err[1], st[0], err[0],
                   FLAG_RSV};

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg     <= CFG_RST;
         wel     <= 1'b0;
         rst_arm <= 1'b0;
      end else begin
         cfg <= next_cfg;
         if (hit && next_rx == C_WREN)
            wel <= 1'b1;
         else if ((hit && next_rx == C_WRDI) || arr_go || cfg_wr || nv_wr)
            wel <= 1'b0;
         if (hit)
            rst_arm <= (next_rx == C_RSTEN);
      end
   end

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_array_start <= 1'b0;
         o_array_code  <= 8'h00;
         o_read_start  <= 1'b0;
         o_read_code   <= 8'h00;
         o_nvcfg_wr    <= 1'b0;
         o_nvcfg_data  <= 16'h0000;
         o_mem_reset   <= 1'b0;
      end else begin
         o_array_start <= arr_go;
         o_read_start  <= hit & is_rd;
         o_nvcfg_wr    <= nv_wr;
         o_mem_reset   <= hit & (next_rx == C_RSTMEM) & rst_arm;
         if (c_arr)
            o_array_code <= next_rx;
         if (hit & is_rd)
            o_read_code <= next_rx;
         if (nv_wr)
            o_nvcfg_data <= {next_rx, nv_lo};
      end
   end

   assign o_protocol   = proto;
   assign o_hold_en    = cfg[CFG_B_HOLD];
   assign o_accel_en   = ~cfg[CFG_B_ACC];
   assign o_drive_code = cfg[2:0];
   assign o_wel        = wel;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n);

   property p_busy;
      i_op_busy |=> !flags[7] ##1 (flags[7] == !$past(i_op_busy));
   endproperty
   a_busy: assert property (p_busy) else $error("busy not shown");
   property p_esusp;
      i_erase_susp && !i_prog_susp |=> flags[6] && !flags[2];
   endproperty
   a_esusp: assert property (p_esusp) else $error("suspend bit");
   property p_selfclr;
      !i_erase_susp && !i_prog_susp |=> !flags[6] && !flags[2];
   endproperty
   a_selfclr: assert property (p_selfclr) else $error("no self clear");
   property p_hold;
      flags[5] && !c_clr |=> flags[5];
   endproperty
   a_hold: assert property (p_hold) else $error("error bit lost");
   property p_clr;
      c_clr && !i_erase_fail && !i_prot_hit |=> !flags[5] && !flags[1];
   endproperty
   a_clr: assert property (p_clr) else $error("clear failed");
   property p_perr;
      c_arr && err_any |=> flags[1] && !o_array_start;
   endproperty
   a_perr: assert property (p_perr) else $error("no protect err");
   property p_wel;
      o_array_start |-> $past(wel) && !wel;
   endproperty
   a_wel: assert property (p_wel) else $error("start w/o enable");

   property p_quad;
      cfg_wr && !next_rx[7] |=> o_protocol == PR_QUAD;
   endproperty
   a_quad: assert property (p_quad) else $error("quad not set");

   property p_inval;
      cmd_done && !cv |=> state == ST_SKIP && $stable(cfg)
                          ##1 o_dq_oe_n == 4'hF;
   endproperty
   a_inval: assert property (p_inval) else $error("bad cmd acted");

   property p_rsv;
      !cfg[CFG_B_RSV] && !flags[0];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bit set");
endmodule

// *** sim/sfc_host.sv ***
`timescale 1ns/10ps
module sfc_host (
   input  wire logic       i_clk,
   input  wire logic [3:0] i_dq,
   input  wire logic [3:0] i_junk,
   output logic            o_sck,
   output logic            o_sel_n,
   output logic [3:0]      o_dq,
   output logic            o_stb,
   output logic [7:0]      o_byte
);
   logic [3:0] tx;
   logic [3:0] msk;
   // lanes not driven carry junk, so a stale level never reads right
   assign o_dq = (tx & msk) | (i_junk & ~msk);
   initial begin
      o_sck = 1'b0;
      o_sel_n = 1'b1;
      o_stb = 1'b0;
      o_byte = 8'h00;
      tx = 4'h0;
      msk = 4'h0;
   end
   always @(posedge i_clk) if (o_stb) o_stb <= 1'b0;
   // half a 160 ns link period
   task half;
      repeat (16) @(posedge i_clk);
      #1;
   endtask
   // mode 0: data set while the link clock is low, sampled on its rise
   task bits(input logic [7:0] v, input int ln, input logic rd);
      logic [7:0] s;
      s = v;
      for (int e = 0; e < 8 / ln; e++) begin
         for (int k = 0; k < ln; k++) tx[ln-1-k] = s[7-k];
         msk = rd ? 4'h0 : 4'hF >> (4 - ln);
         if (!rd) s = s << ln;
         half;
         for (int k = 0; k < ln && rd; k++)
            s = {s[6:0], ln == 1 ? i_dq[1] : i_dq[ln-1-k]};
         o_sck = 1'b1;
         half;
         o_sck = 1'b0;
      end
      if (rd) begin
         o_byte = s;
         o_stb = 1'b1;
      end
   endtask
   // one command per frame; link clock stands still outside it
   task xfer(input logic [7:0] c, input int ln, input int nw,
             input logic [15:0] w, input int nr);
      o_sel_n = 1'b0;
      half;
      bits(c, ln, 1'b0);
      for (int i = 0; i < nw; i++) bits(i ? w[15:8] : w[7:0], ln, 1'b0);
      msk = 4'h0;
      for (int i = 0; i < nr; i++) bits(8'h00, ln, 1'b1);
      half;
      o_sel_n = 1'b1;
      half;
   endtask
endmodule

// *** sim/sfc_cmd_test.sv ***
`timescale 1ns/10ps
module sfc_cmd_test;
   import sfc_pkg::*;
   localparam logic [23:0] IDV = 24'h3C9E47; // arbitrary value
   logic        clk, nrst, busy, esus, psus, efail, pfail, vbad, phit;
   logic [7:0]  stat, ecfg, ef, h_byte, acode, rcode;
   logic [15:0] nv, w, nvdat;
   logic [3:0]  junk, h_dq, dq, oe_n, wdq;
   logic [31:0] rnd;
   logic        sck, sel_n, h_stb, astart, rstart, nvwr, mrst;
   logic        hold, accel, wel;
   logic [1:0]  proto;
   logic [2:0]  drv;
   logic [19:0] q[$];
   int          err_total, n_compared, ln;
   logic [7:0]  wv[7] = '{8'hE4, 8'hD9, 8'hBF, 8'h3F, 8'h7F, 8'hFF, 8'hF8};
   logic [7:0]  pv[3] = '{8'hFF, 8'hBF, 8'h7F};
   logic [7:0]  rc[8] = '{C_RD, C_FRD, C_DOFR, C_DIOFR, C_QOFR, C_QIOFR,
                          C_SFDP, C_RDOTP};
   assign wdq = (~oe_n & dq) | (oe_n & h_dq);
   sfc_host h (.i_clk(clk), .i_dq(wdq), .i_junk(junk), .o_sck(sck),
      .o_sel_n(sel_n), .o_dq(h_dq), .o_stb(h_stb), .o_byte(h_byte));
   sfc_cmd #(.ID_BYTES(IDV)) dut (.i_clk_sys(clk), .i_nrst(nrst),
      .i_link_clk(sck), .i_sel_n(sel_n), .i_dq(wdq), .o_dq(dq),
      .o_dq_oe_n(oe_n), .i_op_busy(busy), .i_erase_susp(esus),
      .i_prog_susp(psus), .i_erase_fail(efail), .i_prog_fail(pfail),
      .i_vpp_bad(vbad), .i_prot_hit(phit), .i_status(stat),
      .i_nvcfg(nv), .o_array_start(astart), .o_array_code(acode),
      .o_read_start(rstart), .o_read_code(rcode), .o_nvcfg_wr(nvwr),
      .o_nvcfg_data(nvdat), .o_mem_reset(mrst), .o_protocol(proto),
      .o_hold_en(hold), .o_accel_en(accel), .o_drive_code(drv),
      .o_wel(wel));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      #1;
      rnd = lfsr(rnd);
      junk = rnd[3:0];
   end
   task test_done;
      $display("compared %0d errors %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t port %h not %h", $time, g, e);
      end
   endtask
   // oldest note must match each result as it shows up
   task see(input logic [19:0] g);
      n_compared++;
      if (q.size() == 0 || q[0] !== g) begin
         err_total++;
         $display("BAD %0t result %h unexpected", $time, g);
      end else
         void'(q.pop_front());
   endtask
   always @(posedge clk) begin
      if (h_stb === 1'b1) see({4'h1, 8'h00, h_byte});
      if (nvwr === 1'b1) see({4'h2, nvdat});
      if (astart === 1'b1) see({4'h3, 8'h00, acode});
      if (rstart === 1'b1) see({4'h4, 8'h00, rcode});
      if (mrst === 1'b1) see({4'h5, 16'h0000});
   end
   task ex(input logic [3:0] k, input logic [15:0] v);
      q.push_back({k, v});
   endtask
   task cmd(input logic [7:0] c, input int nw, input logic [15:0] v,
            input int nr);
      h.xfer(c, ln, nw, v, nr);
   endtask
   task chk65;
      ex(4'h1, ecfg);
      ex(4'h1, ecfg);
      cmd(C_RDEVC, 0, 16'h0000, 2);
      chk({proto, hold, accel, drv}, {ln == 4 ? 2'h2 : ln == 2 ? 2'h1 :
          2'h0, ecfg[4], ~ecfg[3], ecfg[2:0]});
   endtask
   task wcfg(input logic [7:0] v);
      cmd(C_WREN, 0, 16'h0000, 0);
      chk(wel, 1'b1);
      cmd(C_WREVC, 1, {8'h00, v}, 0);
      chk(wel, 1'b0);
      ecfg = {v[7:6], 1'b0, v[4:3], (v[2:0] == DRV_RSV0 ||
              v[2:0] == DRV_RSV1) ? ecfg[2:0] : v[2:0]};
      ln = !v[7] ? 4 : !v[6] ? 2 : 1;
      chk65;
   endtask
   task fl(input logic [6:0] v);
      {busy, esus, efail, pfail, vbad, psus, phit} = v;
      repeat (2) @(posedge clk);
      #1 {efail, pfail, vbad, phit} = 4'h0;
      ef = {~v[6], v[5], ef[5:3] | v[4:2], v[1], ef[1] | v[0], 1'b0};
   endtask
   task rd70;
      ex(4'h1, ef);
      ex(4'h1, ef);
      cmd(C_RDFLG, 0, 16'h0000, 2);
   endtask
   initial begin
      #450000;
      err_total++;
      test_done;
   end
   initial begin
      {busy, esus, efail, pfail, vbad, psus, phit} = 7'h00;
      nrst = 1'b0;
      stat = 8'h00;
      nv = 16'h0000;
      rnd = 32'h00013A4B;
      junk = 4'h0;
      err_total = 0;
      n_compared = 0;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (8) @(posedge clk);
      #1 ln = 1;
      ecfg = CFG_RST;
      ef = 8'h80;
      chk65;
      cmd(C_WREVC, 1, 16'h0012, 0);
      chk65;
      foreach (wv[i]) wcfg(wv[i]);
      foreach (pv[p]) begin
         wcfg(pv[p]);
         foreach (rc[i]) begin
            if (ln == 1 || rc[i] inside {C_FRD, C_SFDP, C_RDOTP} ||
                (ln == 2 ? (rc[i] == C_DOFR
                || rc[i] == C_DIOFR) : (rc[i] == C_QOFR ||
                rc[i] == C_QIOFR))) ex(4'h4, rc[i]);
            cmd(rc[i], 0, 16'h0000, 0);
         end
         for (int i = 0; i < 4 - (ln > 1); i++)
            ex(4'h1, i < 3 ? IDV[23 - 8 * i -: 8] : 8'h00);
         cmd(ln == 1 ? C_ID2 : C_IDM, 0, 16'h0000,
             4 - (ln > 1));
      end
      fl(7'b1100000);
      rd70;
      fl(7'b0011100);
      rd70;
      cmd(C_WREN, 0, 16'h0000, 0);
      cmd(C_PP, 0, 16'h0000, 0);
      ef[1] = 1'b1;
      rd70;
      cmd(C_CLRFLG, 0, 16'h0000, 0);
      ef = ef & 8'hC4;
      rd70;
      fl(7'b0000011);
      rd70;
      cmd(C_CLRFLG, 0, 16'h0000, 0);
      ef = ef & 8'hC4;
      fl(7'b0000000);
      rd70;
      cmd(C_WREN, 0, 16'h0000, 0);
      ex(4'h3, C_SSE);
      cmd(C_SSE, 0, 16'h0000, 0);
      cmd(C_WRDI, 0, 16'h0000, 0);
      cmd(C_BE, 0, 16'h0000, 0);
      nv = rnd[15:0];
      ex(4'h1, nv[7:0]);
      ex(4'h1, nv[15:8]);
      ex(4'h1, 8'h00);
      cmd(C_RDNV, 0, 16'h0000, 3);
      w = rnd[31:16];
      cmd(C_WRNV, 2, w, 0);
      cmd(C_WREN, 0, 16'h0000, 0);
      ex(4'h2, w);
      cmd(C_WRNV, 2, w, 0);
      wcfg(8'hD9);
      cmd(C_RSTMEM, 0, 16'h0000, 0);
      ex(4'h5, 16'h0000);
      cmd(C_RSTEN, 0, 16'h0000, 0);
      cmd(C_RSTMEM, 0, 16'h0000, 0);
      ecfg = CFG_RST;
      chk65;
      stat = rnd[7:0];
      ex(4'h1, stat);
      ex(4'h1, stat);
      cmd(C_RDSR, 0, 16'h0000, 2);
      chk(q.size(), 16'h0000);
      test_done;
   end
endmodule
